//--- wdf_pkg.sv
`default_nettype none
package wdf_pkg;

  // Register indices; byte address is four times the index
  localparam logic [9:0]  CTRL_IDX     = 10'h0a7;
  localparam logic [9:0]  RELOAD_IDX   = 10'h0a8;
  localparam logic [9:0]  FEED1_IDX    = 10'h0a9;
  localparam logic [9:0]  FEED2_IDX    = 10'h0aa;
  localparam logic [9:0]  STATUS_IDX   = 10'h0ab;
  localparam logic [9:0]  MASK_IDX     = 10'h0ac;
  localparam logic [11:0] CTRL_ADDR    = {CTRL_IDX, 2'b00};
  localparam logic [11:0] RELOAD_ADDR  = {RELOAD_IDX, 2'b00};
  localparam logic [11:0] FEED1_ADDR   = {FEED1_IDX, 2'b00};
  localparam logic [11:0] FEED2_ADDR   = {FEED2_IDX, 2'b00};
  localparam logic [11:0] STATUS_ADDR  = {STATUS_IDX, 2'b00};
  localparam logic [11:0] MASK_ADDR    = {MASK_IDX, 2'b00};

  localparam logic [7:0]  FEED1_VAL    = 8'ha5;
  localparam logic [7:0]  FEED2_VAL    = 8'h5a;
  localparam logic [7:0]  RELOAD_RESET = 8'hff;

  localparam int          PRESC_W      = 13;
  localparam logic [3:0]  TAP_BASE     = 4'h5;
  localparam int          ST_W         = 2;
  localparam int          ST_UNDER     = 0;
  localparam int          ST_BAD       = 1;
  localparam int          SRC_N        = 2;
  localparam int          SRC_PCLK     = 0;
  localparam int          SRC_OSC      = 1;
  localparam logic [4:0]  RST_CYCLES   = 5'h10;

  typedef struct packed {
    logic [2:0] tap;
    logic [1:0] rsv;
    logic       run;
    logic       tof;
    logic       clksel;
  } wdf_ctrl_t;

  localparam wdf_ctrl_t   CTRL_RESET   = 8'he5;

  typedef enum logic [1:0] {
    FEED_IDLE   = 2'b00,
    FEED_ARMED  = 2'b01,
    FEED_EXPECT = 2'b10
  } wdf_feed_t;

  typedef struct packed {
    logic        hsel;
    logic [31:0] haddr;
    logic [1:0]  htrans;
    logic        hwrite;
    logic [2:0]  hsize;
    logic [31:0] hwdata;
    logic        hready;
  } wdf_ahb_req_t;

  typedef struct packed {
    logic [31:0] hrdata;
    logic        hreadyout;
    logic        hresp;
  } wdf_ahb_rsp_t;

  typedef struct packed {
    logic [2:0] stage;
    logic       tick;
  } wdf_sync_t;

  typedef struct packed {
    logic [11:0]        addr;
    logic               wr_pend;
    logic               rd_pend;
    logic               hreadyout;
    logic [31:0]        hrdata;
    wdf_ctrl_t          ctrl_sfr;
    logic [7:0]         reload_sfr;
    wdf_ctrl_t          active;
    logic [7:0]         count;
    logic [PRESC_W-1:0] presc;
    wdf_feed_t          feed;
    logic               load_pend;
    logic               ctrl_once;
    logic               reload_once;
    logic [ST_W-1:0]    status;
    logic [ST_W-1:0]    mask;
    logic               irq;
    logic [4:0]         rst_cnt;
    logic               wdt_reset;
  } wdf_state_t;

  localparam wdf_state_t STATE_RESET = '{
    addr: 12'h000, wr_pend: 1'b0, rd_pend: 1'b0, hreadyout: 1'b1,
    hrdata: 32'h0, ctrl_sfr: CTRL_RESET, reload_sfr: RELOAD_RESET,
    active: CTRL_RESET, count: RELOAD_RESET, presc: 13'h0,
    feed: FEED_IDLE, load_pend: 1'b0, ctrl_once: 1'b0,
    reload_once: 1'b0, status: 2'h0, mask: 2'h0, irq: 1'b0,
    rst_cnt: 5'h00, wdt_reset: 1'b0};

endpackage : wdf_pkg
`default_nettype wire

//--- wdf_tick_sync.sv
`default_nettype none
module wdf_tick_sync (
  input  wire logic hclk,
  input  wire logic hresetn,
  input  wire logic level_in,
  output logic      tick
);
  import wdf_pkg::*;

  wdf_sync_t s;
  wdf_sync_t n;

  // Stage 0 feeds only stage 1; edge taken from stages 1 and 2
  always_comb
  begin
    n       = s;
    n.stage = {s.stage[1:0], level_in};
    n.tick  = s.stage[1] & ~s.stage[2];
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      s <= '0;
    else
      s <= n;
  end

  assign tick = s.tick;

endmodule : wdf_tick_sync
`default_nettype wire

//--- wdf_watchdog.sv
// How it works
// - In watchdog mode control and reload sit in shadow until a feed moves them active.
// - Feed is A5 to first feed port then 5A to second port.
// - Reads may come between feed writes; any other write breaks it.
// - In watchdog mode a broken feed raises the watchdog reset at once.
// - In watchdog mode a control write must be followed by a feed.
// - In timer mode control copies every cycle; reload is taken at the next feed or underflow.
// - Timeout is 2^(5+tap)*(reload+1)+1 watchdog clock ticks.
// - Tap select is control bits 7..5; reload is eight bits.
// - Control bit 0 picks oscillator when set, peripheral clock else.
// - Reset enable plus safety lock force oscillator clock select.
// - Timeout flag sets on underflow; watchdog-mode feed or written zero clears.
// - Run bit starts or stops; forced on under enable plus lock.
// - Underflow in watchdog mode raises the watchdog reset.
// - Under enable plus lock, control and reload take one write.
// - Timer mode reloads on underflow and ignores wrong feeds.
// - Counter steps on a tap of a 13-bit prescaler.
`default_nettype none
module wdf_watchdog (
  input  wire logic                  hclk,
  input  wire logic                  hresetn,
  input  wire wdf_pkg::wdf_ahb_req_t ahb_req,
  output var  wdf_pkg::wdf_ahb_rsp_t ahb_rsp,
  input  wire logic                  other_sfr_write,
  input  wire logic                  wd_osc_in,
  input  wire logic                  pclk_in,
  input  wire logic                  reset_on_underflow_enable,
  input  wire logic                  safety_lock_enable,
  output logic                       wdt_reset,
  output logic                       irq,
  output logic                       timeout_flag
);
  import wdf_pkg::*;

  wdf_state_t         s;
  wdf_state_t         n;
  logic [SRC_N-1:0]   src_in;
  logic [SRC_N-1:0]   src_tick;
  logic               tick;
  logic               wd_mode;
  logic               lock;
  logic               take;
  logic               any_wr;
  logic               is_f1;
  logic               is_f2;
  logic               bad;
  logic               feed_ok;
  logic               underflow;
  logic               trigger;
  logic [7:0]         wdat;
  logic [PRESC_W-1:0] tap_mask;
  wdf_ctrl_t          wr_ctrl;

  function automatic wdf_ctrl_t force_ctrl(input wdf_ctrl_t c,
                                           input logic      lk);
    wdf_ctrl_t r;
    r     = c;
    r.rsv = 2'b00;
    if (lk)
    begin
      r.clksel = 1'b1;
      r.run    = 1'b1;
    end
    return r;
  endfunction : force_ctrl

  assign src_in[SRC_PCLK] = pclk_in;
  assign src_in[SRC_OSC]  = wd_osc_in;

  // Both sources are sampled as levels; ticks are one hclk wide
  for (genvar g = 0; g < SRC_N; g++)
  begin : g_src
    wdf_tick_sync wdf_tick_sync_inst (
      .hclk     (hclk),
      .hresetn  (hresetn),
      .level_in (src_in[g]),
      .tick     (src_tick[g])
    );
  end

  assign tick = src_tick[s.active.clksel];

  always_comb
  begin
    n        = s;
    wd_mode  = reset_on_underflow_enable;
    lock     = reset_on_underflow_enable & safety_lock_enable;
    wdat     = ahb_req.hwdata[7:0];
    wr_ctrl  = wdf_ctrl_t'(wdat);
    bad      = 1'b0;
    feed_ok  = 1'b0;
    underflow = 1'b0;
    take     = ahb_req.hsel & ahb_req.htrans[1] & ahb_req.hready;

    // Address phase; reads get one wait state so they see fresh state
    n.wr_pend   = take & ahb_req.hwrite;
    n.rd_pend   = take & ~ahb_req.hwrite;
    n.hreadyout = ~(take & ~ahb_req.hwrite);
    if (take)
      n.addr = ahb_req.haddr[11:0];

    if (s.rd_pend)
    begin
      case (s.addr)
        CTRL_ADDR:   n.hrdata = {24'h0, force_ctrl(s.ctrl_sfr, lock)};
        RELOAD_ADDR: n.hrdata = {24'h0, s.reload_sfr};
        STATUS_ADDR:
        begin
          n.hrdata = {30'h0, s.status};
          n.status = '0;
        end
        MASK_ADDR:   n.hrdata = {30'h0, s.mask};
        default:     n.hrdata = 32'h0;
      endcase
    end

    // Feed sequence checker; a write from elsewhere counts as a break
    any_wr = s.wr_pend | other_sfr_write;
    is_f1  = s.wr_pend & ~other_sfr_write & (s.addr == FEED1_ADDR)
             & (wdat == FEED1_VAL);
    is_f2  = s.wr_pend & ~other_sfr_write & (s.addr == FEED2_ADDR)
             & (wdat == FEED2_VAL);
    case (s.feed)
      FEED_IDLE:
      begin
        if (is_f1)
          n.feed = FEED_ARMED;
        else if (s.wr_pend && wd_mode && s.addr == CTRL_ADDR)
          n.feed = FEED_EXPECT;
        else if (s.wr_pend &&
                 (s.addr == FEED1_ADDR || s.addr == FEED2_ADDR))
          bad = 1'b1;
      end
      FEED_EXPECT:
      begin
        if (any_wr)
        begin
          if (is_f1)
            n.feed = FEED_ARMED;
          else
          begin
            bad    = 1'b1;
            n.feed = FEED_IDLE;
          end
        end
      end
      FEED_ARMED:
      begin
        if (any_wr)
        begin
          n.feed = FEED_IDLE;
          if (is_f2)
            feed_ok = 1'b1;
          else
            bad = 1'b1;
        end
      end
      default: n.feed = FEED_IDLE;
    endcase

    if (s.wr_pend)
    begin
      case (s.addr)
        CTRL_ADDR:
        begin
          if (!(lock && s.ctrl_once))
          begin
            n.ctrl_sfr     = wr_ctrl;
            n.ctrl_sfr.rsv = 2'b00;
            n.ctrl_sfr.tof = s.ctrl_sfr.tof & wr_ctrl.tof;
            n.ctrl_once    = 1'b1;
          end
        end
        RELOAD_ADDR:
        begin
          if (!(lock && s.reload_once))
          begin
            n.reload_sfr  = wdat;
            n.reload_once = 1'b1;
          end
        end
        MASK_ADDR: n.mask = wdat[ST_W-1:0];
        default: ;
      endcase
    end

    if (!wd_mode)
      n.active = force_ctrl(s.ctrl_sfr, 1'b0);

    // Counter runs on watchdog ticks; a pending load wins over counting
    tap_mask = ~(13'h1fff << (TAP_BASE + {1'b0, s.active.tap}));
    if (tick)
    begin
      if (s.load_pend)
      begin
        n.count     = s.reload_sfr;
        n.presc     = '0;
        n.load_pend = 1'b0;
      end
      else if (s.active.run)
      begin
        n.presc = s.presc + 13'h1;
        if ((s.presc & tap_mask) == tap_mask)
        begin
          if (s.count == 8'h00)
          begin
            underflow = 1'b1;
            n.count   = s.reload_sfr;
          end
          else
            n.count = s.count - 8'h01;
        end
      end
    end

    // Feed placed after the tick so a new load is never dropped
    if (feed_ok)
    begin
      if (wd_mode)
      begin
        n.active       = force_ctrl(s.ctrl_sfr, lock);
        n.ctrl_sfr.tof = 1'b0;
      end
      n.load_pend = 1'b1;
    end

    // Hardware sets placed last so they win over any clear
    if (underflow)
      n.ctrl_sfr.tof = 1'b1;
    n.status[ST_UNDER] = n.status[ST_UNDER] | underflow;
    n.status[ST_BAD]   = n.status[ST_BAD] | (bad & wd_mode);

    trigger = wd_mode & (bad | underflow);
    if (s.rst_cnt != 5'h00)
      n.rst_cnt = s.rst_cnt - 5'h01;
    if (trigger)
    begin
      // Acts like power-on for the core but keeps bus and causes
      n.ctrl_sfr     = CTRL_RESET;
      n.ctrl_sfr.tof = 1'b1;
      n.reload_sfr   = RELOAD_RESET;
      n.active       = CTRL_RESET;
      n.count        = RELOAD_RESET;
      n.presc        = '0;
      n.feed         = FEED_IDLE;
      n.load_pend    = 1'b0;
      n.ctrl_once    = 1'b0;
      n.reload_once  = 1'b0;
      n.rst_cnt      = RST_CYCLES;
    end
    n.wdt_reset = (n.rst_cnt != 5'h00);
    n.irq       = |(n.status & n.mask);
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      s <= STATE_RESET;
    else
      s <= n;
  end

  assign ahb_rsp = '{hrdata: s.hrdata, hreadyout: s.hreadyout,
                     hresp: 1'b0};
  assign wdt_reset         = s.wdt_reset;
  assign irq               = s.irq;
  assign timeout_flag      = s.ctrl_sfr.tof;

  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);

  feed_load_a: assert property (
    (s.feed == FEED_ARMED) && is_f2 |=> s.load_pend || s.wdt_reset)
    else $error("valid feed did not post a load");

  shadow_hold_a: assert property (
    wd_mode && !feed_ok && !trigger |=> s.active == $past(s.active))
    else $error("active control changed without a feed");

  broken_feed_a: assert property (
    wd_mode && (s.feed == FEED_ARMED) && other_sfr_write
    |=> s.wdt_reset [*2])
    else $error("write between feed halves did not reset");

  bad_feed_a: assert property (
    wd_mode && (s.feed == FEED_IDLE) && s.wr_pend && !other_sfr_write
    && (s.addr == FEED2_ADDR) |=> s.wdt_reset && s.rst_cnt == RST_CYCLES)
    else $error("stray second feed write did not reset");

  ctrl_feed_a: assert property (
    wd_mode && (s.feed == FEED_EXPECT) && any_wr && !is_f1
    |=> s.wdt_reset)
    else $error("control write not followed by feed");

  timer_copy_a: assert property (
    !wd_mode |=> s.active.tap == $past(s.ctrl_sfr.tap))
    else $error("timer mode did not copy control");

  lock_force_a: assert property (
    lock && $past(lock) |-> s.active.clksel && s.active.run)
    else $error("lock did not force clock select and run");

  underflow_a: assert property (
    underflow && wd_mode |=> s.wdt_reset && s.ctrl_sfr.tof ##15 s.wdt_reset
    ##1 !s.wdt_reset || $past(trigger))
    else $error("underflow reset wrong length");

  write_once_a: assert property (
    lock && s.ctrl_once && s.wr_pend && (s.addr == CTRL_ADDR) && !trigger
    |=> s.ctrl_sfr.tap == $past(s.ctrl_sfr.tap))
    else $error("locked control accepted a second write");

  timer_reload_a: assert property (
    underflow && !wd_mode |=> s.count == $past(s.reload_sfr)
    && !$past(trigger))
    else $error("timer mode underflow did not reload");

  feed_restart_a: assert property (
    tick && s.load_pend && !trigger
    |=> s.presc == 13'h0 && s.count == $past(s.reload_sfr))
    else $error("feed load did not restart prescaler");

  tap_step_a: assert property (
    tick && !s.load_pend && s.active.run && s.count != 8'h00
    && ((s.presc & tap_mask) == tap_mask) && !trigger
    |=> s.count == $past(s.count) - 8'h01)
    else $error("counter missed its prescaler tap");

endmodule : wdf_watchdog
`default_nettype wire

//--- wdf_tb_top.sv
`default_nettype none
module watchdog_feed_and_timeout_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  import wdf_pkg::*;

  logic         hclk = 1'b0;
  logic         hresetn = 1'b0;
  logic         hsel = 1'b0;
  logic [11:0]  haddr = 12'h000;
  logic [1:0]   htrans = 2'b00;
  logic         hwrite = 1'b0;
  logic [31:0]  hwdata = 32'h0;
  logic         osfr = 1'b0;
  logic         osc = 1'b0;
  logic         pclk = 1'b0;
  logic         ruoe = 1'b0;
  logic         lock = 1'b0;
  logic [3:0]   oc = 4'h0;
  logic [3:0]   pc = 4'h0;
  int           oticks = 0;
  int           pticks = 0;
  int           t0 = 0;
  int           n_mismatch = 0;
  int           checks_done = 0;
  logic [31:0]  rd;
  wdf_ahb_req_t req;
  wdf_ahb_rsp_t rsp;
  logic         wdt_reset;
  logic         irq;
  logic         tof;

  // Single slave, so its hreadyout is the bus hready
  assign req = {hsel, 20'h0, haddr, htrans, hwrite, 3'h2, hwdata,
                rsp.hreadyout};

  wdf_watchdog wdf_watchdog_inst (
    .hclk                      (hclk),
    .hresetn                   (hresetn),
    .ahb_req                   (req),
    .ahb_rsp                   (rsp),
    .other_sfr_write           (osfr),
    .wd_osc_in                 (osc),
    .pclk_in                   (pclk),
    .reset_on_underflow_enable (ruoe),
    .safety_lock_enable        (lock),
    .wdt_reset                 (wdt_reset),
    .irq                       (irq),
    .timeout_flag              (tof)
  );

  always #25 hclk = ~hclk;

  // Slow tick sources, well below half the bus clock rate
  always @(posedge hclk)
  begin
    oc <= (oc == 4'h7) ? 4'h0 : oc + 4'h1;
    pc <= (pc == 4'h5) ? 4'h0 : pc + 4'h1;
    if (oc == 4'h7)
    begin
      osc <= ~osc;
      if (!osc)
        oticks <= oticks + 1;
    end
    if (pc == 4'h5)
    begin
      pclk <= ~pclk;
      if (!pclk)
        pticks <= pticks + 1;
    end
  end

  task automatic print_verdict;
    $display("checks %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : print_verdict

  task automatic cmp_val(input logic [31:0] got, input logic [31:0] exp,
                         input string m);
    checks_done++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("[FAIL] %0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask : cmp_val

  task automatic cmp_bit(input logic got, input logic exp, input string m);
    cmp_val({31'h0, got}, {31'h0, exp}, m);
  endtask : cmp_bit

  task automatic xfer(input logic w, input logic [11:0] a,
                      input logic [7:0] d);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= a;
    htrans <= 2'b10;
    hwrite <= w;
    do @(posedge hclk); while (rsp.hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= {24'h0, d};
    do @(posedge hclk); while (rsp.hreadyout !== 1'b1);
    rd = rsp.hrdata;
  endtask : xfer

  task automatic rchk(input logic [11:0] a, input logic [31:0] exp,
                      input string m);
    xfer(1'b0, a, 8'h00);
    cmp_val(rd, exp, m);
    cmp_bit(rsp.hresp, 1'b0, m);
  endtask : rchk

  // Second write lands mid tick period so no tick is in flight
  task automatic feed(input logic o);
    int t;
    xfer(1'b1, FEED1_ADDR, FEED1_VAL);
    t = o ? oticks : pticks;
    while ((o ? oticks : pticks) == t)
      @(posedge hclk);
    repeat (5) @(posedge hclk);
    xfer(1'b1, FEED2_ADDR, FEED2_VAL);
    t0 = o ? oticks : pticks;
  endtask : feed

  task automatic wait_uf(input logic o, input int exp);
    // No limit here; the run watchdog ends a hang
    while (tof !== 1'b1 && wdt_reset !== 1'b1)
      @(posedge hclk);
    cmp_val((o ? oticks : pticks) - t0, exp, "ticks to underflow");
  endtask : wait_uf

  task automatic check_rst(input string m);
    int n;
    for (n = 0; n < 6 && wdt_reset !== 1'b1; n++)
      @(posedge hclk);
    for (n = 0; n < 40 && wdt_reset === 1'b1; n++)
      @(posedge hclk);
    cmp_val(n, 16, m);
  endtask : check_rst

  task automatic no_rst(input string m);
    logic seen;
    seen = 1'b0;
    repeat (20)
    begin
      @(posedge hclk);
      seen = seen | wdt_reset;
    end
    cmp_bit(seen, 1'b0, m);
  endtask : no_rst

  // Fuse levels only change while reset is held
  task automatic do_reset(input logic e, input logic l);
    @(posedge hclk);
    hresetn <= 1'b0;
    ruoe <= e;
    lock <= l;
    repeat (5) @(posedge hclk);
    hresetn <= 1'b1;
  endtask : do_reset

  initial
  begin
    #2000000;
    n_mismatch++;
    $display("[FAIL] %0t run hung", $time);
    print_verdict();
  end

  initial
  begin
    do_reset(1'b0, 1'b0);
    rchk(CTRL_ADDR, 32'he5, "ctrl reset");
    rchk(RELOAD_ADDR, 32'hff, "reload reset");
    rchk(12'h300, 32'h0, "unmapped read");
    cmp_bit(tof, 1'b0, "flag reset");
    xfer(1'b1, RELOAD_ADDR, 8'h00);
    xfer(1'b1, CTRL_ADDR, 8'h04);
    xfer(1'b1, MASK_ADDR, 8'h01);
    repeat (40) @(posedge hclk);
    rchk(CTRL_ADDR, 32'h04, "ctrl shadow");
    feed(1'b0);
    wait_uf(1'b0, 33);
    repeat (3) @(posedge hclk);
    cmp_bit(irq, 1'b1, "irq on underflow");
    rchk(STATUS_ADDR, 32'h01, "status set");
    rchk(STATUS_ADDR, 32'h00, "status cleared");
    repeat (2) @(posedge hclk);
    cmp_bit(irq, 1'b0, "irq cleared");
    xfer(1'b1, CTRL_ADDR, 8'h04);
    repeat (2) @(posedge hclk);
    cmp_bit(tof, 1'b0, "flag written zero");
    xfer(1'b1, MASK_ADDR, 8'h00);
    // Reload of zero underflows again 32 ticks later
    wait_uf(1'b0, 65);
    repeat (3) @(posedge hclk);
    cmp_bit(tof, 1'b1, "timer reloads");
    cmp_bit(irq, 1'b0, "irq masked");
    xfer(1'b1, MASK_ADDR, 8'h01);
    repeat (3) @(posedge hclk);
    cmp_bit(irq, 1'b1, "irq unmasked");
    xfer(1'b1, FEED1_ADDR, 8'h11);
    xfer(1'b1, FEED2_ADDR, FEED2_VAL);
    no_rst("timer bad feed");
    xfer(1'b1, CTRL_ADDR, 8'h00);
    repeat (450) @(posedge hclk);
    cmp_bit(tof, 1'b0, "run stopped");
    $display("test timer mode done");

    do_reset(1'b1, 1'b0);
    xfer(1'b1, FEED1_ADDR, FEED1_VAL);
    rchk(CTRL_ADDR, 32'he5, "read inside feed");
    xfer(1'b1, FEED2_ADDR, FEED2_VAL);
    no_rst("good feed");
    xfer(1'b1, FEED1_ADDR, 8'h5a);
    check_rst("wrong first value");
    rchk(STATUS_ADDR, 32'h02, "bad feed status");
    xfer(1'b1, FEED2_ADDR, FEED2_VAL);
    check_rst("second alone");
    xfer(1'b1, FEED1_ADDR, FEED1_VAL);
    xfer(1'b1, MASK_ADDR, 8'h00);
    check_rst("bus write in feed");
    xfer(1'b1, FEED1_ADDR, FEED1_VAL);
    @(posedge hclk);
    osfr <= 1'b1;
    @(posedge hclk);
    osfr <= 1'b0;
    check_rst("other write in feed");
    xfer(1'b1, CTRL_ADDR, 8'he5);
    xfer(1'b1, RELOAD_ADDR, 8'h00);
    check_rst("ctrl write no feed");
    xfer(1'b1, RELOAD_ADDR, 8'h00);
    xfer(1'b1, CTRL_ADDR, 8'h25);
    feed(1'b1);
    wait_uf(1'b1, 65);
    check_rst("underflow reset");
    rchk(CTRL_ADDR, 32'he7, "ctrl after reset");
    feed(1'b1);
    repeat (2) @(posedge hclk);
    cmp_bit(tof, 1'b0, "feed clears flag");
    $display("test watchdog mode done");

    do_reset(1'b1, 1'b1);
    xfer(1'b1, CTRL_ADDR, 8'h00);
    feed(1'b1);
    rchk(CTRL_ADDR, 32'h05, "forced bits");
    xfer(1'b1, CTRL_ADDR, 8'he0);
    feed(1'b1);
    rchk(CTRL_ADDR, 32'h05, "second write");
    no_rst("locked feeds");
    $display("test locked mode done");
    print_verdict();
  end

endmodule : watchdog_feed_and_timeout_tb_top
`default_nettype wire
